// ### ssp_pkg.sv
// shared constants and types for the synchronous serial port core
// assumes one system clock; all users import ssp_pkg::*
package ssp_pkg;

	// ----------------------------------------------------------------
	// data path geometry
	// ----------------------------------------------------------------
	localparam int SSP_DATA_W     = 16;       // widest frame and fifo word
	localparam int SSP_FIFO_DEPTH = 8;        // transmit and receive fifo depth
	localparam int SSP_SKID_DEPTH = 2;        // skid buffer in front of the cpu read side
	localparam int SSP_LVL_W      = 4;        // width of an 8-deep fifo level
	localparam int SSP_SKID_LVL_W = 2;        // width of a 2-deep buffer level

	// ----------------------------------------------------------------
	// frame formats and engine states
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SSP_FMT_SPI  = 2'b00,                 // four-wire polarity/phase format
		SSP_FMT_SYNC = 2'b01,                 // frame-pulse synchronous format
		SSP_FMT_CMD  = 2'b10                  // half-duplex command/response format
	} ssp_fmt_type;

	typedef enum logic [1:0]
	{
		SSP_ST_IDLE  = 2'b00,                 // nothing on the wire
		SSP_ST_LEAD  = 2'b01,                 // frame signal set up before the clock
		SSP_ST_SHIFT = 2'b10,                 // clock edges running
		SSP_ST_TRAIL = 2'b11                  // frame signal held after last bit
	} ssp_state_type;

	// ----------------------------------------------------------------
	// configuration limits and timing counts
	// ----------------------------------------------------------------
	localparam logic [3:0] SSP_MIN_SIZE_CODE = 4'h3;   // size code 3 means 4 bits
	localparam logic [6:0] SSP_MIN_PRE_HALF  = 7'h01;  // prescale 2 gives one cycle per half
	localparam logic [4:0] SSP_CMD_BITS      = 5'h08;  // command message length
	localparam logic [4:0] SSP_CMD_GAP       = 5'h01;  // dead clock before the response
	localparam logic [4:0] SSP_CMD_MSB       = 5'h07;  // msb index of the command word
	localparam logic [1:0] SSP_LEAD_SPI      = 2'h1;   // half periods of select before clock
	localparam logic [1:0] SSP_LEAD_SYNC     = 2'h2;   // frame pulse lasts one whole period
	localparam logic [1:0] SSP_TRAIL_HALVES  = 2'h2;   // select held one period after last bit
	localparam logic [7:0] SSP_RTO_HALVES    = 8'h40;  // idle half periods before timeout
	localparam logic [3:0] SSP_TX_SERV_LVL   = 4'h4;   // tx service at or below half full
	localparam logic [3:0] SSP_RX_SERV_LVL   = 4'h4;   // rx service at or above half full

	// ----------------------------------------------------------------
	// interrupt source positions
	// ----------------------------------------------------------------
	localparam int SSP_IRQ_TX  = 0;           // transmit fifo service
	localparam int SSP_IRQ_RX  = 1;           // receive fifo service
	localparam int SSP_IRQ_RTO = 2;           // receive timeout
	localparam int SSP_IRQ_ROR = 3;           // receive overrun

endpackage

// ### ssp_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes single clock; used for the 8-deep fifos and the 2-entry skid buffer
module ssp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int LVL_W = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// draining side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready,
	// fill level
	output logic      [LVL_W-1:0] level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0]    LAST = AW'(DEPTH - 1);   // highest index
	localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);    // level when full

	logic [WIDTH-1:0] mem_q [DEPTH];      // storage, indexed by pointer
	logic [AW-1:0]    wr_q;               // next slot to write
	logic [AW-1:0]    rd_q;               // oldest slot
	logic [LVL_W-1:0] cnt_q;              // entries held
	logic             push;
	logic             pop;

	// full and empty come straight from the count, so they never lie
	assign in_ready  = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign level     = cnt_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// wrap a pointer at the last slot
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == LAST) ? '0 : p + 1'b1;
	endfunction

	// storage has no reset; unread slots are never presented
	always_ff @(posedge clk_sys)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= bump(wr_q);
			end
			if (pop)
			begin
				rd_q <= bump(rd_q);
			end
			if (push && !pop)
			begin
				cnt_q <= cnt_q + 1'b1;
			end
			else if (pop && !push)
			begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ### ssp_core.sv
// synchronous serial port: bit-rate generator, fifos, shift engine, interrupts
// assumes control ports are held steady while a frame runs and that pin
// inputs are already synchronous to clk_sys
//
// Function
// [RULE1] prescale clock by even divisor 2 to 254
// [RULE2] then divide by rate field plus one
// [RULE3] serial clock equals system clock over product
// [RULE4] master: system clock at least twice serial
// [RULE5] slave: system clock twelve times serial clock
// [RULE6] transmit fifo, sixteen bits, eight entries
// [RULE7] receive fifo, sixteen bits, eight entries
// [RULE8] serialize transmit words onto transmit line
// [RULE9] shift in receive bits, load word to fifo
// [RULE10] four interrupt conditions detected
// [RULE11] enabled interrupts ORed into one request
// [RULE12] per-source mask bit, one enables
// [RULE13] raw and masked status both readable
// [RULE14] individual output for each interrupt source
// [RULE15] fifo-level interrupts apart from error interrupts
// [RULE16] frame size four to sixteen bits
// [RULE17] master or slave, three frame formats
// [RULE18] internal loopback from transmit to receive
// [RULE19] most significant bit sent first
// [RULE20] serial clock idle except during transfers
// [RULE21] timeout when clock idle and data waiting
// [RULE22] overrun when receive fifo full, frame dropped
module ssp_core
	import ssp_pkg::*;
(
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// configuration
	input  wire logic                        port_enable,
	input  wire logic                        master_mode,
	input  wire ssp_pkg::ssp_fmt_type        frame_format,
	input  wire logic                        clk_polarity,
	input  wire logic                        clk_phase,
	input  wire logic                        loopback,
	input  wire logic [3:0]                  data_size_code,
	input  wire logic [7:0]                  clock_prescale_divisor,
	input  wire logic [7:0]                  serial_clock_rate_field,
	// interrupt control
	input  wire logic [3:0]                  irq_mask,
	input  wire logic                        clear_timeout,
	input  wire logic                        clear_overrun,
	// cpu write side of the transmit fifo
	input  wire logic                        tx_wr_valid,
	input  wire logic [ssp_pkg::SSP_DATA_W-1:0] tx_wr_data,
	output logic                             tx_wr_ready,
	// cpu read side of the receive path
	output logic                             rx_rd_valid,
	output logic [ssp_pkg::SSP_DATA_W-1:0]   rx_rd_data,
	input  wire logic                        rx_rd_ready,
	// status
	output logic [ssp_pkg::SSP_LVL_W-1:0]    tx_level,
	output logic [ssp_pkg::SSP_LVL_W-1:0]    rx_level,
	output logic                             port_busy,
	// interrupts
	output logic [3:0]                       irq_raw,
	output logic [3:0]                       irq_masked,
	output logic                             irq_combined,
	// serial pins
	output logic                             serial_clock_out,
	output logic                             serial_clock_oe_n,
	input  wire logic                        serial_clock_in,
	output logic                             frame_out,
	output logic                             frame_oe_n,
	input  wire logic                        frame_in,
	output logic                             transmit_data_line,
	output logic                             transmit_data_oe_n,
	input  wire logic                        receive_data_line
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ssp_state_type       state_q;          // engine state
	logic                sclk_q;           // master serial clock level
	logic [5:0]          edge_q;           // clock edges seen in this frame
	logic [1:0]          wait_q;           // half periods spent in lead/trail
	logic [15:0]         tx_sh_q;          // transmit shifter
	logic [15:0]         rx_sh_q;          // receive shifter
	logic [15:0]         rx_word_q;        // completed word awaiting the fifo
	logic                rx_push_q;        // one-cycle push strobe
	logic                sclk_prev_q;      // slave clock pin, previous cycle
	logic                frame_prev_q;     // slave frame pin, previous cycle
	logic [6:0]          pre_cnt_q;        // prescale counter
	logic [7:0]          rate_q;           // post-divide counter
	logic [7:0]          rto_cnt_q;        // idle half periods
	logic                rto_q;            // sticky timeout
	logic                ror_q;            // sticky overrun

	logic                eff_pol;          // clock idle level for this format
	logic                eff_pha;          // 1: sample on second edge
	logic [4:0]          periods;          // serial periods per frame
	logic [5:0]          last_edge;        // index of final edge
	logic [6:0]          pre_half;         // cycles per prescaled tick
	logic                pre_tick;
	logic                half_tick;        // one serial half period elapsed
	logic                edge_ev;          // an edge of the serial clock
	logic                sample_edge;
	logic [4:0]          bit_idx;
	logic [3:0]          msb;
	logic                tx_bit;
	logic                rx_bit;
	logic                do_sample;
	logic [15:0]         rx_next;
	logic                frame_fall;
	logic                start;
	logic                tx_valid;
	logic [15:0]         tx_data;
	logic                rx_in_ready;
	logic                rxf_valid;
	logic [15:0]         rxf_data;
	logic                skid_ready;
	logic [1:0]          skid_level;
	logic                rx_held;

	// ----------------------------------------------------------------
	// format decode
	// ----------------------------------------------------------------
	// periods in a frame; response format adds command and dead clock
	function automatic logic [4:0] frame_periods(input ssp_fmt_type f, input logic [3:0] c);
		logic [4:0] bits;
		bits = {1'b0, (c < SSP_MIN_SIZE_CODE) ? SSP_MIN_SIZE_CODE : c} + 5'h01; // [RULE16]
		frame_periods = (f == SSP_FMT_CMD) ? bits + SSP_CMD_BITS + SSP_CMD_GAP : bits;
	endfunction

	// synchronous format drives on rising and latches on falling edges
	assign eff_pol   = (frame_format == SSP_FMT_SPI) ? clk_polarity : 1'b0; // [RULE17]
	assign eff_pha   = (frame_format == SSP_FMT_SPI) ? clk_phase
	                 : (frame_format == SSP_FMT_SYNC);                     // [RULE17]
	assign periods   = frame_periods(frame_format, data_size_code);
	assign last_edge = {periods, 1'b0} - 6'h01;

	// ----------------------------------------------------------------
	// bit-rate generator
	// ----------------------------------------------------------------
	// half of the even prescale; bit 0 of the divisor is ignored
	assign pre_half  = (clock_prescale_divisor[7:1] < SSP_MIN_PRE_HALF)
	                 ? SSP_MIN_PRE_HALF : clock_prescale_divisor[7:1];      // [RULE1]
	assign pre_tick  = (pre_cnt_q == pre_half - 7'h01); // [RULE1]
	assign half_tick = pre_tick && (rate_q == serial_clock_rate_field);    // [RULE2]

	// free-running dividers; one full serial period is two half ticks, so
	// the period is prescale * (1 + rate) system clocks
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_cnt_q <= '0;
			rate_q    <= '0;
		end
		else if (pre_tick)
		begin
			pre_cnt_q <= '0;
			rate_q    <= half_tick ? 8'h00 : rate_q + 8'h01; // [RULE3]
		end
		else
		begin
			pre_cnt_q <= pre_cnt_q + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	// transmit fifo: cpu pushes, the engine pops at frame start
	ssp_fifo #(.WIDTH(SSP_DATA_W), .DEPTH(SSP_FIFO_DEPTH), .LVL_W(SSP_LVL_W)) u_tx_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (tx_wr_valid),
		.in_data   (tx_wr_data),
		.in_ready  (tx_wr_ready),
		.out_valid (tx_valid),
		.out_data  (tx_data),
		.out_ready (start),
		.level     (tx_level)
	); // [RULE6]

	// receive fifo: engine pushes completed words
	ssp_fifo #(.WIDTH(SSP_DATA_W), .DEPTH(SSP_FIFO_DEPTH), .LVL_W(SSP_LVL_W)) u_rx_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (rx_push_q),
		.in_data   (rx_word_q),
		.in_ready  (rx_in_ready),
		.out_valid (rxf_valid),
		.out_data  (rxf_data),
		.out_ready (skid_ready),
		.level     (rx_level)
	); // [RULE7]

	// skid buffer lets the cpu stall its read without losing a word
	ssp_fifo #(.WIDTH(SSP_DATA_W), .DEPTH(SSP_SKID_DEPTH), .LVL_W(SSP_SKID_LVL_W)) u_rx_skid (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (rxf_valid),
		.in_data   (rxf_data),
		.in_ready  (skid_ready),
		.out_valid (rx_rd_valid),
		.out_data  (rx_rd_data),
		.out_ready (rx_rd_ready),
		.level     (skid_level)
	);

	assign rx_held = rxf_valid || (skid_level != '0);

	// ----------------------------------------------------------------
	// shift datapath
	// ----------------------------------------------------------------
	assign bit_idx     = edge_q[5:1];
	assign sample_edge = (edge_q[0] == eff_pha);
	assign msb         = (frame_format == SSP_FMT_CMD) ? SSP_CMD_MSB[3:0] : 4'(periods - 5'h01);
	assign tx_bit      = tx_sh_q[msb];                                      // [RULE19]
	assign rx_bit      = loopback ? tx_bit : receive_data_line;             // [RULE18]
	// no capture while the command message is going out
	assign do_sample   = edge_ev && sample_edge && ((frame_format != SSP_FMT_CMD)
	                   || (bit_idx >= SSP_CMD_BITS + SSP_CMD_GAP));
	assign rx_next     = do_sample ? {rx_sh_q[14:0], rx_bit} : rx_sh_q;     // [RULE9]

	// master counts its own half ticks; slave watches the pin for changes,
	// which only works while the system clock is well above the pin rate
	assign edge_ev    = (state_q == SSP_ST_SHIFT) && (master_mode ? half_tick
	                  : (serial_clock_in != sclk_prev_q));                  // [RULE5]
	assign frame_fall = frame_prev_q && !frame_in;
	assign start      = (state_q == SSP_ST_IDLE) && port_enable
	                  && (master_mode ? tx_valid : frame_fall);              // [RULE17]

	// shifters: load at start; receive shifts on sampling edges, transmit on non-sampling edges after the first
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sh_q <= '0;
			rx_sh_q <= '0;
		end
		else if (start)
		begin
			// a slave with nothing queued sends zeros
			tx_sh_q <= tx_valid ? tx_data : 16'h0000;                          // [RULE8]
			rx_sh_q <= '0;
		end
		else if (edge_ev)
		begin
			rx_sh_q <= rx_next;
			if (!sample_edge && (edge_q != '0))
			begin
				tx_sh_q <= {tx_sh_q[14:0], 1'b0};                              // [RULE19]
			end
		end
	end

	// completed word handed to the receive fifo one cycle later
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_word_q <= '0;
			rx_push_q <= 1'b0;
		end
		else
		begin
			rx_push_q <= edge_ev && (edge_q == last_edge);                     // [RULE9]
			if (edge_ev && (edge_q == last_edge))
			begin
				rx_word_q <= rx_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= SSP_ST_IDLE;
			edge_q  <= '0;
			wait_q  <= '0;
			sclk_q  <= 1'b0;
		end
		else
		begin
			case (state_q)
				SSP_ST_IDLE:
				begin
					sclk_q <= eff_pol;                                         // [RULE20]
					edge_q <= '0;
					wait_q <= '0;
					if (start)
					begin
						state_q <= master_mode ? SSP_ST_LEAD : SSP_ST_SHIFT;
					end
				end
				SSP_ST_LEAD:
				begin
					// select or frame pulse settles before the first edge
					if (half_tick)
					begin
						wait_q <= wait_q + 2'h1;
						if (wait_q + 2'h1 == ((frame_format == SSP_FMT_SYNC)
						    ? SSP_LEAD_SYNC : SSP_LEAD_SPI))
						begin
							state_q <= SSP_ST_SHIFT;
							wait_q  <= '0;
						end
					end
				end
				SSP_ST_SHIFT:
				begin
					if (!master_mode && (frame_format != SSP_FMT_SYNC) && frame_in)
					begin
						// master dropped select mid-word: abandon it
						state_q <= SSP_ST_IDLE;
					end
					else if (edge_ev)
					begin
						edge_q <= edge_q + 6'h01;
						sclk_q <= master_mode ? !sclk_q : sclk_q;              // [RULE3]
						if (edge_q == last_edge)
						begin
							state_q <= master_mode ? SSP_ST_TRAIL : SSP_ST_IDLE;
						end
					end
				end
				SSP_ST_TRAIL:
				begin
					sclk_q <= eff_pol;                                         // [RULE20]
					if (half_tick)
					begin
						wait_q <= wait_q + 2'h1;
						if (wait_q + 2'h1 == SSP_TRAIL_HALVES)
						begin
							state_q <= SSP_ST_IDLE;
						end
					end
				end
				default:
				begin
					state_q <= SSP_ST_IDLE;
				end
			endcase
		end
	end

	// slave pin history for edge and select detection
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_prev_q  <= 1'b0;
			frame_prev_q <= 1'b0;
		end
		else
		begin
			sclk_prev_q  <= serial_clock_in;
			frame_prev_q <= frame_in;
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// master drives clock and frame; slave leaves those pads off
	assign serial_clock_out   = sclk_q;                                     // [RULE20]
	assign serial_clock_oe_n  = !(port_enable && master_mode);
	assign frame_oe_n         = !(port_enable && master_mode);
	assign frame_out          = (frame_format == SSP_FMT_SYNC) ? (state_q == SSP_ST_LEAD)
	                          : (state_q == SSP_ST_IDLE);
	assign transmit_data_line = tx_bit;                                     // [RULE8]
	// response phase of the command format belongs to the far end
	assign transmit_data_oe_n = !(port_enable && (state_q != SSP_ST_IDLE)
	                          && !((frame_format == SSP_FMT_CMD) && (bit_idx >= SSP_CMD_BITS)));
	assign port_busy          = (state_q != SSP_ST_IDLE) || tx_valid;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// timeout counts idle half periods while words sit unread
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rto_cnt_q <= '0;
			rto_q     <= 1'b0;
		end
		else
		begin
			if ((state_q != SSP_ST_IDLE) || !rx_held)
			begin
				rto_cnt_q <= '0;
			end
			else if (half_tick && (rto_cnt_q != SSP_RTO_HALVES))
			begin
				rto_cnt_q <= rto_cnt_q + 8'h01;
			end
			// a new timeout in the clearing cycle wins
			if (half_tick && (rto_cnt_q == SSP_RTO_HALVES - 8'h01) && rx_held
			    && (state_q == SSP_ST_IDLE))
			begin
				rto_q <= 1'b1;                                                 // [RULE21]
			end
			else if (clear_timeout)
			begin
				rto_q <= 1'b0;
			end
		end
	end

	// overrun: word arrives at a full fifo and is dropped there
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ror_q <= 1'b0;
		end
		else if (rx_push_q && !rx_in_ready)
		begin
			ror_q <= 1'b1;                                                     // [RULE22]
		end
		else if (clear_overrun)
		begin
			ror_q <= 1'b0;
		end
	end

	// level sources track the fifos; status sources are sticky
	assign irq_raw[SSP_IRQ_TX]  = port_enable && (tx_level <= SSP_TX_SERV_LVL); // [RULE15]
	assign irq_raw[SSP_IRQ_RX]  = (rx_level >= SSP_RX_SERV_LVL);               // [RULE15]
	assign irq_raw[SSP_IRQ_RTO] = rto_q;                                       // [RULE10]
	assign irq_raw[SSP_IRQ_ROR] = ror_q;                                       // [RULE10]
	assign irq_masked           = irq_raw & irq_mask; // [RULE12] [RULE13] [RULE14]
	assign irq_combined         = |irq_masked; // [RULE11]
endmodule

// ### ssp_core_assertions.sv
// port checker for ssp_core
// assumes a bind onto ssp_core and one clock domain
module ssp_core_chk
	import ssp_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 port_enable,
	input wire logic                 master_mode,
	input wire ssp_pkg::ssp_fmt_type frame_format,
	input wire logic                 clk_polarity,
	input wire logic [3:0]           irq_mask,
	input wire logic                 clear_timeout,
	input wire logic                 clear_overrun,
	input wire logic                 tx_wr_ready,
	input wire logic                 rx_rd_valid,
	input wire logic [15:0]          rx_rd_data,
	input wire logic                 rx_rd_ready,
	input wire logic [3:0]           tx_level,
	input wire logic [3:0]           rx_level,
	input wire logic                 port_busy,
	input wire logic [3:0]           irq_raw,
	input wire logic [3:0]           irq_masked,
	input wire logic                 irq_combined,
	input wire logic                 serial_clock_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// a word offered but not yet taken
	sequence s_rx_held;
		rx_rd_valid && !rx_rd_ready;
	endsequence
	a_masked_and: assert property (irq_masked == (irq_raw & irq_mask))
		else $error("masked status wrong");
	a_combined_or: assert property (irq_combined == |irq_masked)
		else $error("combined request wrong");
	a_clk_idle: assert property (master_mode && !port_busy && frame_format == SSP_FMT_SPI
		|-> serial_clock_out == clk_polarity) else $error("serial clock moved while idle");
	a_tx_full: assert property (tx_wr_ready == (tx_level != 4'h8))
		else $error("write ready wrong");
	a_rx_stands: assert property (s_rx_held |=> rx_rd_valid && $stable(rx_rd_data))
		else $error("read word lost");
	a_rto_sticky: assert property (irq_raw[2] && !clear_timeout |=> irq_raw[2])
		else $error("timeout flag dropped");
	a_ror_sticky: assert property (irq_raw[3] && !clear_overrun |=> irq_raw[3])
		else $error("overrun flag dropped");
	a_tx_serv: assert property (irq_raw[0] == (port_enable && tx_level <= 4'h4))
		else $error("tx service wrong");
	a_rx_serv: assert property (irq_raw[1] == (rx_level >= 4'h4))
		else $error("rx service wrong");
endmodule
bind ssp_core ssp_core_chk chk (.*);

// ### ssp_peer.sv
// serial slave model, clock idle low, sample on rising edge, msb first
// assumes an active low select from the port under test
module ssp_peer (
	input  wire logic        sclk,
	input  wire logic        sel_n,
	input  wire logic        mosi,
	output logic             miso,
	input  wire logic [15:0] reply,
	output logic      [15:0] got
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sh_q = 16'h0000; // outgoing bits, msb on the line
	initial got = 16'h0000;
	// new frame: load the answer, forget the old word
	always @(negedge sel_n)
	begin
		sh_q = reply;
		got = 16'h0000;
	end
	always @(posedge sclk) if (!sel_n) got = {got[14:0], mosi};
	always @(negedge sclk) if (!sel_n) sh_q = sh_q << 1;
	// released line shows the inverse so a stale bit never passes
	assign miso = sel_n ? ~sh_q[15] : sh_q[15];
endmodule

// ### tb.sv
// bench for ssp_core as master against a serial slave model
// assumes a 20 MHz clock
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ssp_pkg::*;
	logic        clk_sys = 1'b0, rst_n = 1'b0, en = 1'b1, lb = 1'b0, clr = 1'b0;
	logic        wr_valid = 1'b0, rd_ready = 1'b0, wr_ready, rd_valid, busy, comb;
	logic        sck, sck_oe_n, fr, fr_oe_n, txd, txd_oe_n, rxd;
	logic [15:0] wr_data = 16'h0000, rd_data, got;
	logic [7:0]  div = 8'h04, rate = 8'h02; // slow enough for the slave
	logic [3:0]  mask = 4'h0, lvl_tx, lvl_rx, raw, msk;
	int          num_errors = 0, checks = 0;
	wire         sck_pad = sck_oe_n ? 1'b0 : sck; // pull-down
	wire         fr_pad = fr_oe_n ? 1'b1 : fr;    // pull-up
	ssp_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .port_enable(en), .master_mode(1'b1),
		.frame_format(SSP_FMT_SPI), .clk_polarity(1'b0), .clk_phase(1'b0), .loopback(lb),
		.data_size_code(4'h7), .clock_prescale_divisor(div), .serial_clock_rate_field(rate),
		.irq_mask(mask), .clear_timeout(clr), .clear_overrun(clr), .tx_wr_valid(wr_valid),
		.tx_wr_data(wr_data), .tx_wr_ready(wr_ready), .rx_rd_valid(rd_valid),
		.rx_rd_data(rd_data), .rx_rd_ready(rd_ready), .tx_level(lvl_tx), .rx_level(lvl_rx),
		.port_busy(busy), .irq_raw(raw), .irq_masked(msk), .irq_combined(comb),
		.serial_clock_out(sck), .serial_clock_oe_n(sck_oe_n), .serial_clock_in(sck_pad),
		.frame_out(fr), .frame_oe_n(fr_oe_n), .frame_in(fr_pad), .transmit_data_line(txd),
		.transmit_data_oe_n(txd_oe_n), .receive_data_line(rxd));
	ssp_peer peer (.sclk(sck_pad), .sel_n(fr_pad), .mosi(txd), .miso(rxd),
		.reply(16'h3c00), .got(got));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask
	// valid is left high so words can follow back to back
	task automatic push(input logic [15:0] w);
		wr_valid = 1'b1;
		wr_data = w;
		while (wr_ready !== 1'b1) cyc(1);
		cyc(1);
	endtask
	task automatic pop(input logic [15:0] exp);
		while (rd_valid !== 1'b1) cyc(1);
		cmp("read word", exp, rd_data);
		rd_ready = 1'b1;
		cyc(1);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_master;
		time t0;
		cmp("raw irq after reset", 16'h0001, 16'(raw));
		push(16'h12a5);
		wr_valid = 1'b0;
		@(posedge sck_pad);
		t0 = $time;
		@(posedge sck_pad);
		cmp("clock period ns", 16'h0258, 16'($time - t0));
		pop(16'h003c);
		rd_ready = 1'b0;
		cmp("peer word", 16'h00a5, got);
	endtask
	// eleven words against ten places: the last is dropped
	task automatic t_overrun;
		cyc(30);
		lb = 1'b1;
		div = 8'h02; // two system cycles per serial period
		rate = 8'h00;
		for (int i = 1; i <= 11; i++) push(16'(i));
		wr_valid = 1'b0;
		while (busy !== 1'b0) cyc(1);
		cyc(100);
		cmp("raw irq", 16'h000f, 16'(raw));
		mask = 4'h8;
		cyc(1);
		cmp("combined", 16'h0001, 16'(comb));
		mask = 4'h0;
		cyc(1);
		cmp("combined masked", 16'h0000, 16'(comb));
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(1);
		cmp("overrun flag", 16'h0000, 16'(raw[3]));
		for (int i = 1; i <= 10; i++) pop(16'(i));
		rd_ready = 1'b0;
		cyc(2);
		cmp("read valid", 16'h0000, 16'(rd_valid));
	endtask
	initial forever #25 clk_sys = ~clk_sys;
	initial
	begin
		cyc(4);
		rst_n = 1'b1;
		cyc(1);
		t_master();
		t_overrun();
		stop_test();
	end
	// hang guard, far past the run's length
	initial
	begin
		cyc(20000);
		num_errors++;
		stop_test();
	end
endmodule
